// [mcc_pkg.sv]
package mcc_pkg;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0] MCC_OFF_SEL = 8'h00;    // main_clock_select_ctrl
  localparam logic [7:0] MCC_OFF_PRESC = 8'h01;  // main_clock_prescale_ctrl
  localparam logic [7:0] MCC_OFF_FDCTL = 8'h02;  // clock_failure_detect_ctrl
  localparam logic [7:0] MCC_OFF_IRQCTL = 8'h03; // clock_failure_irq_ctrl
  localparam logic [7:0] MCC_OFF_FLAGS = 8'h04;  // clock_failure_irq_flags
  localparam logic [7:0] MCC_OFF_STATUS = 8'h05; // main_clock_status

  // ****************************************
  // field positions
  // ****************************************
  localparam int MCC_B_MAIN_CLOCK_OUT_ENABLE = 7;
  localparam int MCC_B_SRC_LO = 0;
  localparam int MCC_B_PEN = 0;
  localparam int MCC_B_PRESCALE_RATIO_LO = 1;
  localparam int MCC_B_FDEN = 0;
  localparam int MCC_B_FDTST = 1;
  localparam int MCC_B_FDSRC_LO = 2;
  localparam int MCC_B_IRQEN = 0;
  localparam int MCC_B_IRQKIND = 7;
  localparam int MCC_B_FLAG = 0;
  localparam int MCC_B_PENDING = 0;
  localparam int MCC_B_INTHF = 1;
  localparam int MCC_B_INT32K = 2;
  localparam int MCC_B_EXT32K = 3;
  localparam int MCC_B_EXTHF = 4;
  localparam int MCC_B_PLL = 5;

  // ****************************************
  // codes, reset values and counts
  // ****************************************
  localparam logic [3:0] MCC_SRC_INT_HF = 4'h0;
  localparam logic [3:0] MCC_SRC_INT_32K = 4'h1;
  localparam logic [3:0] MCC_SRC_EXT_32K = 4'h2;
  localparam logic [3:0] MCC_SRC_EXT_HF = 4'h3;
  localparam logic [1:0] MCC_MON_MAIN = 2'h0;
  localparam logic [1:0] MCC_MON_EXT_HF = 2'h1;
  localparam logic [1:0] MCC_MON_EXT_32K = 2'h2;
  localparam logic [7:0] MCC_REG_RESET = 8'h00;
  localparam logic [3:0] MCC_REPEAT_TICKS = 4'hA; // slow-osc cycles between re-raises
  localparam logic [2:0] MCC_GUARD_INSTRS = 3'h4; // instructions a key stays open

  typedef enum logic [0:0] {
    MCC_SW_IDLE = 1'b0,
    MCC_SW_WAIT = 1'b1
  } mcc_sw_t;

endpackage : mcc_pkg

// [mcc_main_clock_ctrl.sv]
// What this block does
// [R1] main_clock_out_enable gate high only while enable bit set and main clock runs
// [R2] enable bit follows writes, cleared by a failure on the monitored main clock
// [R3] source field codes: 0 int hf, 1 int 32k, 2 ext 32k, 3 ext hf
// [R4] source 3 picks ext input or crystal by the ext hf select bit
// [R5] ratio codes 0-5 give 2..64, codes 8-C give 6,10,12,24,48
// [R6] prescale off passes every cycle, on divides by selected ratio
// [R7] software keeps source and ratio within allowed clock maximum
// [R8] monitor field picks main, ext hf or ext 32k, only while enabled
// [R9] enable, irq enable and kind all set lock four fields until reset
// [R10] test bit written 1 forces a failure, written 0 ends it
// [R11] detector runs only while its enable bit is set
// [R12] kind bit picks regular interrupt or non-maskable interrupt
// [R13] interrupt requested only while irq enable bit is set
// [R14] failure flag set on any detected or forced failure
// [R15] writing 1 clears the flag, writing 0 leaves it
// [R16] pll status bit shows pll running
// [R17] ext hf status shows crystal stable or input running per select bit
// [R18] ext 32k status shows crystal stable or input running per select bit
// [R19] internal hf and 32k status bits show oscillator stability
// [R20] writes to protected registers take effect only within four instructions after a key
// [R21] persisting failure re-raises flag every ten slow oscillator cycles
// [R22] main clock failure switches source to the fused start-up source
// [R23] pending bit high while a source change waits for a stable source
// [R24] unimplemented bits read zero and ignore writes
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
module mcc_main_clock_ctrl (
  input wire logic CLOCK,                 // 200 MHz system clock
  input wire logic RST_N,                 // synchronous reset, active low
  input wire logic [7:0] ADDR,            // register offset
  input wire logic [7:0] WDATA,           // write data
  input wire logic WR,                    // write strobe
  input wire logic RD,                    // read strobe
  output logic [7:0] RDATA,               // read data, cycle after RD
  input wire logic GUARD_KEY,             // pulse: key written to the guard
  input wire logic INSTR_DONE,            // pulse: one cpu instruction retired
  input wire logic [3:0] FUSE_STARTUP_SRC, // fused start-up source code
  input wire logic EXT_HF_SELECT_CLOCK,   // 1 ext hf input, 0 ext hf crystal
  input wire logic EXT_32K_SELECT_CLOCK,  // 1 ext 32k input, 0 ext 32k crystal
  input wire logic INT_HF_STABLE,         // async: internal hf osc stable
  input wire logic INT_32K_STABLE,        // async: internal 32k osc stable
  input wire logic XTAL_32K_STABLE,       // async: 32k crystal stable
  input wire logic EXT_32K_RUNNING,       // async: 32k input clock running
  input wire logic XTAL_HF_STABLE,        // async: hf crystal stable
  input wire logic EXT_HF_RUNNING,        // async: hf input clock running
  input wire logic PLL_RUNNING,           // async: pll running
  input wire logic MAIN_RUNNING,          // async: main clock toggling
  input wire logic INT_32K_CLK,           // async: internal slow osc output
  input wire logic MAIN_FAIL,             // async: main clock stopped
  input wire logic EXT_HF_FAIL,           // async: ext hf source stopped
  input wire logic EXT_32K_FAIL,          // async: ext 32k source stopped
  output logic [3:0] ACTIVE_SRC,          // source code steering the clock mux
  output logic EXT_HF_USE_INPUT,          // ext hf path takes the input pin
  output logic MAIN_CLOCK_OUT_ENABLE_GATE,               // gate of main clock onto the pin
  output logic CPU_CLK_EN,                // cpu/peripheral clock enable
  output logic FAIL_IRQ,                  // regular failure interrupt request
  output logic FAIL_NMI                   // non-maskable failure request
);
  import mcc_pkg::*;

  // ****************************************
  // state
  // ****************************************
  localparam int NSYNC = 12;

  typedef struct packed {
    logic main_clock_out_enable;
    logic [3:0] src_sel;
    logic prescale_enable;
    logic [3:0] prescale_ratio;
    logic [1:0] mon;
    logic tst;
    logic fd_en;
    logic irq_kind;
    logic irq_en;
    logic flag;
    logic locked;
    mcc_sw_t sw;
    logic [3:0] active;
    logic [5:0] div_cnt;
    logic clk_en;
    logic [3:0] rep_cnt;
    logic fail_prev;
    logic tick_prev;
    logic [2:0] guard_cnt;
    logic [7:0] rdata;
    logic [NSYNC-1:0] sync1;
    logic [NSYNC-1:0] sync2;
  } mcc_state_t;

  localparam mcc_state_t ST_RESET = '{
    main_clock_out_enable: 1'b0, src_sel: MCC_SRC_INT_HF, prescale_enable: 1'b0, prescale_ratio: 4'h0, mon: MCC_MON_MAIN,
    tst: 1'b0, fd_en: 1'b0, irq_kind: 1'b0, irq_en: 1'b0, flag: 1'b0, locked: 1'b0,
    sw: MCC_SW_IDLE, active: MCC_SRC_INT_HF, div_cnt: 6'h00, clk_en: 1'b0,
    rep_cnt: 4'h0, fail_prev: 1'b0, tick_prev: 1'b0, guard_cnt: 3'h0,
    rdata: MCC_REG_RESET, sync1: '0, sync2: '0
  };

  mcc_state_t st;
  mcc_state_t next_st;

  // synchronised copies of the async inputs
  logic s_int_hf, s_int_32k, s_x32k, s_e32k, s_xhf, s_ehf, s_pll, s_main_run;
  logic s_tick, s_fail_main, s_fail_hf, s_fail_32k;
  assign {s_fail_32k, s_fail_hf, s_fail_main, s_tick, s_main_run, s_pll,
          s_ehf, s_xhf, s_e32k, s_x32k, s_int_32k, s_int_hf} = st.sync2;

  // ****************************************
  // helper functions
  // ****************************************
  // terminal count of the prescaler; reserved codes fall back to divide by 2
  function automatic logic [5:0] mcc_div_term(input logic [3:0] code);
    logic [5:0] t;
    t = 6'h01;
    unique case (code) // [R5]
      4'h0: t = 6'h01;
      4'h1: t = 6'h03;
      4'h2: t = 6'h07;
      4'h3: t = 6'h0F;
      4'h4: t = 6'h1F;
      4'h5: t = 6'h3F;
      4'h8: t = 6'h05;
      4'h9: t = 6'h09;
      4'hA: t = 6'h0B;
      4'hB: t = 6'h17;
      4'hC: t = 6'h2F;
      default: t = 6'h01;
    endcase
    return t;
  endfunction : mcc_div_term

  // ****************************************
  // combinational status
  // ****************************************
  logic st_ext_hf, st_ext_32k, guard_open, wr_prot;
  logic fail_cond, fail_rise, tick_rise, repeat_hit, set_flag, main_fail_evt;
  logic target_stable;
  logic [7:0] status_word;

  // crystal or input status follows the select bits of the oscillator registers
  assign st_ext_hf = EXT_HF_SELECT_CLOCK ? s_ehf : s_xhf;     // [R17]
  assign st_ext_32k = EXT_32K_SELECT_CLOCK ? s_e32k : s_x32k; // [R18]

  // unused positions stay zero
  always_comb begin
    status_word = 8'h00; // [R24]
    status_word[MCC_B_PLL] = s_pll; // [R16]
    status_word[MCC_B_EXTHF] = st_ext_hf;
    status_word[MCC_B_EXT32K] = st_ext_32k;
    status_word[MCC_B_INT32K] = s_int_32k; // [R19]
    status_word[MCC_B_INTHF] = s_int_hf; // [R19]
    status_word[MCC_B_PENDING] = (st.sw == MCC_SW_WAIT); // [R23]
  end

  // the guard window counts retired instructions, not bus cycles
  assign guard_open = (st.guard_cnt != 3'h0); // [R20]
  assign wr_prot = WR && guard_open && (ADDR <= MCC_OFF_IRQCTL); // [R20]

  // the detector watches one source, and the test bit stands in for a real stop
  always_comb begin
    fail_cond = 1'b0;
    if (st.fd_en) begin // [R11]
      unique case (st.mon) // [R8]
        MCC_MON_MAIN: fail_cond = s_fail_main;
        MCC_MON_EXT_HF: fail_cond = s_fail_hf;
        MCC_MON_EXT_32K: fail_cond = s_fail_32k;
        default: fail_cond = 1'b0;
      endcase
      fail_cond = fail_cond || st.tst; // [R10]
    end
  end

  assign tick_rise = s_tick && !st.tick_prev;
  assign fail_rise = fail_cond && !st.fail_prev;
  assign repeat_hit = fail_cond && tick_rise && (st.rep_cnt == MCC_REPEAT_TICKS - 4'h1);
  assign set_flag = fail_rise || repeat_hit; // [R14] [R21]
  assign main_fail_evt = fail_rise && (st.mon == MCC_MON_MAIN); // [R22]

  // a reserved code never reports stable, so such a switch never completes
  always_comb begin
    unique case (st.src_sel) // [R3]
      MCC_SRC_INT_HF: target_stable = s_int_hf;
      MCC_SRC_INT_32K: target_stable = s_int_32k;
      MCC_SRC_EXT_32K: target_stable = st_ext_32k;
      MCC_SRC_EXT_HF: target_stable = st_ext_hf;
      default: target_stable = 1'b0;
    endcase
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    next_st = st;
    next_st.sync1 = {EXT_32K_FAIL, EXT_HF_FAIL, MAIN_FAIL, INT_32K_CLK, MAIN_RUNNING,
                     PLL_RUNNING, EXT_HF_RUNNING, XTAL_HF_STABLE, EXT_32K_RUNNING,
                     XTAL_32K_STABLE, INT_32K_STABLE, INT_HF_STABLE};
    next_st.sync2 = st.sync1;
    next_st.tick_prev = s_tick;
    next_st.fail_prev = fail_cond;

    // guard window: key opens it, each instruction shortens it
    if (GUARD_KEY) begin
      next_st.guard_cnt = MCC_GUARD_INSTRS; // [R20]
    end else if (INSTR_DONE && guard_open) begin
      next_st.guard_cnt = st.guard_cnt - 3'h1;
    end

    // register writes, protected ones only inside the window
    if (wr_prot && ADDR == MCC_OFF_SEL) begin
      next_st.main_clock_out_enable = WDATA[MCC_B_MAIN_CLOCK_OUT_ENABLE]; // [R2]
      next_st.src_sel = WDATA[MCC_B_SRC_LO +: 4];
    end
    if (wr_prot && ADDR == MCC_OFF_PRESC) begin
      next_st.prescale_enable = WDATA[MCC_B_PEN];
      next_st.prescale_ratio = WDATA[MCC_B_PRESCALE_RATIO_LO +: 4];
    end
    if (wr_prot && ADDR == MCC_OFF_FDCTL) begin
      next_st.tst = WDATA[MCC_B_FDTST]; // [R10]
      if (!st.locked) begin // [R9]
        next_st.fd_en = WDATA[MCC_B_FDEN];
        next_st.mon = WDATA[MCC_B_FDSRC_LO +: 2];
      end
    end
    if (wr_prot && ADDR == MCC_OFF_IRQCTL && !st.locked) begin // [R9]
      next_st.irq_en = WDATA[MCC_B_IRQEN];
      next_st.irq_kind = WDATA[MCC_B_IRQKIND];
    end

    // lock is sticky until reset
    if (st.fd_en && st.irq_en && st.irq_kind) begin
      next_st.locked = 1'b1; // [R9]
    end

    // flag: a set in the same cycle as the clear wins
    if (WR && ADDR == MCC_OFF_FLAGS && WDATA[MCC_B_FLAG]) begin
      next_st.flag = 1'b0; // [R15]
    end
    if (set_flag) begin
      next_st.flag = 1'b1; // [R14]
    end

    // ten slow-oscillator ticks between re-raises of a standing failure
    if (!fail_cond || fail_rise) begin
      next_st.rep_cnt = 4'h0;
    end else if (tick_rise) begin
      next_st.rep_cnt = repeat_hit ? 4'h0 : st.rep_cnt + 4'h1; // [R21]
    end

    // main clock failure: fall back to the fused source, drop the clock pin
    if (main_fail_evt) begin
      next_st.main_clock_out_enable = 1'b0; // [R2]
      next_st.src_sel = FUSE_STARTUP_SRC; // [R22]
    end

    // source switch waits for the new source to be stable
    unique case (st.sw)
      MCC_SW_IDLE: begin
        if (next_st.src_sel != st.active) begin
          next_st.sw = MCC_SW_WAIT; // [R23]
        end
      end
      MCC_SW_WAIT: begin
        if (st.src_sel == st.active) begin
          next_st.sw = MCC_SW_IDLE;
        end else if (target_stable) begin
          next_st.active = st.src_sel; // [R23]
          next_st.sw = (next_st.src_sel != st.src_sel) ? MCC_SW_WAIT : MCC_SW_IDLE;
        end
      end
    endcase

    // prescaler as a clock enable; a ratio change already applies to the count in progress
    if (!st.prescale_enable) begin
      next_st.div_cnt = 6'h00;
      next_st.clk_en = 1'b1; // [R6]
    end else if (st.div_cnt >= mcc_div_term(st.prescale_ratio)) begin
      next_st.div_cnt = 6'h00;
      next_st.clk_en = 1'b1; // [R5] [R6]
    end else begin
      next_st.div_cnt = st.div_cnt + 6'h01;
      next_st.clk_en = 1'b0;
    end

    // read data, registered one cycle after the strobe
    next_st.rdata = 8'h00;
    if (RD) begin
      unique case (ADDR)
        MCC_OFF_SEL: next_st.rdata = {st.main_clock_out_enable, 3'b000, st.src_sel};
        MCC_OFF_PRESC: next_st.rdata = {3'b000, st.prescale_ratio, st.prescale_enable};
        MCC_OFF_FDCTL: next_st.rdata = {4'h0, st.mon, st.tst, st.fd_en};
        MCC_OFF_IRQCTL: next_st.rdata = {st.irq_kind, 6'h00, st.irq_en};
        MCC_OFF_FLAGS: next_st.rdata = {7'h00, st.flag};
        MCC_OFF_STATUS: next_st.rdata = status_word;
        default: next_st.rdata = 8'h00; // [R24]
      endcase
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      st <= ST_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign RDATA = st.rdata;
  assign ACTIVE_SRC = st.active;
  assign EXT_HF_USE_INPUT = (st.active == MCC_SRC_EXT_HF) && EXT_HF_SELECT_CLOCK; // [R4]
  assign MAIN_CLOCK_OUT_ENABLE_GATE = st.main_clock_out_enable && s_main_run; // [R1]
  assign CPU_CLK_EN = st.clk_en;
  // software stops repeats by clearing the enable; the flag itself stays
  assign FAIL_IRQ = st.flag && st.irq_en && !st.irq_kind; // [R12] [R13]
  assign FAIL_NMI = st.flag && st.irq_en && st.irq_kind; // [R12] [R13]

  // ****************************************
  // assertions
  // ****************************************
  default clocking mcc_cb @(posedge CLOCK);
  endclocking
  default disable iff (!RST_N);

  a_flag_set: assert property (set_flag |=> st.flag) // [R14]
    else $error("failure flag not set after a failure");
  a_flag_clear: assert property ( // [R15]
    WR && ADDR == MCC_OFF_FLAGS && WDATA[MCC_B_FLAG] && !set_flag |=> !st.flag)
    else $error("failure flag not cleared by a one");
  a_flag_keep: assert property ( // [R15]
    st.flag && WR && ADDR == MCC_OFF_FLAGS && !WDATA[MCC_B_FLAG] |=> st.flag)
    else $error("failure flag lost on a zero write");
  a_lock_hold: assert property ( // [R9]
    st.locked && WR |=> $stable(st.fd_en) && $stable(st.mon) && $stable(st.irq_kind)
      && $stable(st.irq_en))
    else $error("locked field changed");
  a_main_clock_out_enable_fail: assert property (main_fail_evt |=> !st.main_clock_out_enable && !MAIN_CLOCK_OUT_ENABLE_GATE) // [R2]
    else $error("clock pin enable kept after main failure");
  a_pin_gate: assert property (MAIN_CLOCK_OUT_ENABLE_GATE == (st.main_clock_out_enable && $past(MAIN_RUNNING, 2))) // [R1]
    else $error("clock pin gated without enable");
  a_guard_block: assert property ( // [R20]
    WR && ADDR == MCC_OFF_SEL && !guard_open && !main_fail_evt |=> $stable(st.src_sel))
    else $error("protected write accepted without key");
  a_presc_off: assert property (!st.prescale_enable && RST_N |=> CPU_CLK_EN) // [R6]
    else $error("clock enable dropped while prescaler off");
  a_div2_gap: assert property ( // [R5]
    st.prescale_enable && st.prescale_ratio == 4'h0 && st.clk_en ##1 st.prescale_enable && st.prescale_ratio == 4'h0 |-> !st.clk_en
      ##1 st.clk_en)
    else $error("divide by two enable spacing wrong");
  a_irq_kind: assert property (FAIL_NMI |-> !FAIL_IRQ && st.irq_kind) // [R12]
    else $error("non-maskable request of wrong kind");
  a_irq_gate: assert property (!st.irq_en |-> !FAIL_IRQ && !FAIL_NMI) // [R13]
    else $error("request issued while disabled");
  a_no_detect: assert property (!st.fd_en && !st.flag |=> !st.flag) // [R11]
    else $error("failure detected while detector off");
  a_switch_wait: assert property ( // [R23]
    st.sw == MCC_SW_WAIT && !target_stable |=> $stable(st.active))
    else $error("source changed before it was stable");
  a_fuse_fallback: assert property ( // [R22]
    main_fail_evt |=> st.src_sel == $past(FUSE_STARTUP_SRC))
    else $error("no fallback to start-up source");

  c_fail_seen: cover property (set_flag ##[1:20] WR && ADDR == MCC_OFF_FLAGS);
  c_locked: cover property (!st.locked ##1 st.locked);
  c_switch_done: cover property (st.sw == MCC_SW_WAIT ##1 st.sw == MCC_SW_IDLE);
  c_repeat: cover property (repeat_hit);

endmodule : mcc_main_clock_ctrl

// [mcc_main_clock_ctrl_tb.sv]
`timescale 1ns/1ps
module mcc_main_clock_ctrl_tb;
  import mcc_pkg::*;
  // ****************************************
  // stimulus and observed signals
  // ****************************************
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic w_stb = 1'b0;
  logic r_stb = 1'b0;
  logic guard_key = 1'b0;
  logic instr_done = 1'b0;
  logic [3:0] fuse_src = 4'h2;
  logic hf_sel = 1'b0;
  logic k32_sel = 1'b0;
  logic [7:0] osc = 8'h00; // pll, stability and running levels, main_run on top
  logic slow_clk = 1'b0;
  logic hf_fail = 1'b0;
  logic main_fail = 1'b0;
  logic k32_fail = 1'b0;
  logic [7:0] rdata;
  logic [3:0] active_src;
  logic use_input, main_clock_out_enable_gate, cpu_en, irq, nmi;
  logic [31:0] r;
  logic [7:0] v;
  logic [3:0] codes [11] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC};
  int seed = 32'h3760;
  int bad_count = 0;
  int n_compared = 0;
  int p;

  always #2.5 clock = ~clock;

  // failure inputs are async levels; the main clock fallback also goes through the test bit
  mcc_main_clock_ctrl DUT (
    .CLOCK(clock), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(w_stb), .RD(r_stb),
    .RDATA(rdata), .GUARD_KEY(guard_key), .INSTR_DONE(instr_done),
    .FUSE_STARTUP_SRC(fuse_src), .EXT_HF_SELECT_CLOCK(hf_sel),
    .EXT_32K_SELECT_CLOCK(k32_sel), .INT_HF_STABLE(osc[0]), .INT_32K_STABLE(osc[1]),
    .XTAL_32K_STABLE(osc[2]), .EXT_32K_RUNNING(osc[3]), .XTAL_HF_STABLE(osc[4]),
    .EXT_HF_RUNNING(osc[5]), .PLL_RUNNING(osc[6]), .MAIN_RUNNING(osc[7]),
    .INT_32K_CLK(slow_clk), .MAIN_FAIL(main_fail), .EXT_HF_FAIL(hf_fail),
    .EXT_32K_FAIL(k32_fail),
    .ACTIVE_SRC(active_src), .EXT_HF_USE_INPUT(use_input), .MAIN_CLOCK_OUT_ENABLE_GATE(main_clock_out_enable_gate),
    .CPU_CLK_EN(cpu_en), .FAIL_IRQ(irq), .FAIL_NMI(nmi)
  );

  // ****************************************
  // helpers
  // ****************************************
  task summarize;
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : summarize

  task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // key pulse, then n retired instructions, then the write; key 0 skips the guard
  task reg_wr(input logic [7:0] a, input logic [7:0] d, input bit key, input int n);
    if (key) begin
      @(posedge clock) guard_key <= 1'b1;
      @(posedge clock) guard_key <= 1'b0;
      if (n > 0) begin
        instr_done <= 1'b1;
        repeat (n) @(posedge clock);
        instr_done <= 1'b0;
      end
    end
    @(posedge clock);
    w_stb <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock) w_stb <= 1'b0;
  endtask : reg_wr

  task rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    r_stb <= 1'b1;
    addr <= a;
    @(posedge clock) r_stb <= 1'b0;
    #1 chk(what, exp, rdata);
  endtask : rd_chk

  task look(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : look

  // bounded wait for the mux code; a hang shows up as a mismatch
  task wait_src(input logic [3:0] e);
    int k;
    k = 0;
    while (active_src !== e && k < 20) begin
      look(1);
      k++;
    end
    chk("active source", {4'h0, e}, {4'h0, active_src});
    if (active_src !== e) summarize();
  endtask : wait_src

  // cycles between two clock enable pulses
  task period(output int n);
    int k;
    k = 0;
    n = 0;
    do begin look(1); k++; end while (cpu_en !== 1'b1 && k < 200);
    do begin look(1); n++; end while (cpu_en !== 1'b1 && n < 200);
    if (n >= 200 || k >= 200) begin
      bad_count++;
      $display("[FAIL] cpu clock enable expected pulses seen none");
      summarize();
    end
  endtask : period

  // slow oscillator edges, wide enough for the synchroniser
  task slow_ticks(input int n);
    repeat (n) begin
      @(posedge clock) slow_clk <= 1'b1;
      repeat (4) @(posedge clock);
      slow_clk <= 1'b0;
      repeat (4) @(posedge clock);
    end
  endtask : slow_ticks

  function automatic logic [7:0] exp_status(input logic [7:0] o, input logic pend);
    return {2'b00, o[6], hf_sel ? o[5] : o[4], k32_sel ? o[3] : o[2], o[1], o[0], pend};
  endfunction : exp_status

  function automatic int ratio(input logic [3:0] c);
    case (c)
      4'h0: return 2;
      4'h1: return 4;
      4'h2: return 8;
      4'h3: return 16;
      4'h4: return 32;
      4'h5: return 64;
      4'h8: return 6;
      4'h9: return 10;
      4'hA: return 12;
      4'hB: return 24;
      4'hC: return 48;
      default: return 2;
    endcase
  endfunction : ratio

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (100000) @(posedge clock);
    bad_count++;
    $display("[FAIL] run length expected under limit seen overrun");
    summarize();
  end

  initial begin
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    for (logic [7:0] a = 8'h00; a < 8'h07; a++) rd_chk("reset value", a, 8'h00);
    $display("test reset values done");
    // guard: no key, key with four instructions gone, key with three
    reg_wr(MCC_OFF_SEL, 8'h80, 0, 0);
    rd_chk("unkeyed write", MCC_OFF_SEL, 8'h00);
    reg_wr(MCC_OFF_SEL, 8'h80, 1, 4);
    rd_chk("stale key write", MCC_OFF_SEL, 8'h00);
    reg_wr(MCC_OFF_SEL, 8'hF0, 1, 3);
    rd_chk("keyed write", MCC_OFF_SEL, 8'h80);
    reg_wr(MCC_OFF_PRESC, 8'hFF, 1, 0);
    rd_chk("prescale fields", MCC_OFF_PRESC, 8'h1F);
    reg_wr(MCC_OFF_STATUS, 8'hFF, 1, 0);
    $display("test guard done");
    // random oscillator levels against status and clock out gate
    repeat (8) begin
      @(posedge clock);
      r = $random(seed);
      osc <= r[7:0];
      hf_sel <= r[8];
      k32_sel <= r[9];
      look(5);
      chk("clock out gate", {7'h0, osc[7]}, {7'h0, main_clock_out_enable_gate});
      rd_chk("status", MCC_OFF_STATUS, exp_status(osc, 1'b0));
    end
    reg_wr(MCC_OFF_SEL, 8'h00, 1, 0);
    @(posedge clock) osc <= 8'hFF;
    look(5);
    chk("clock out off", 8'h00, {7'h0, main_clock_out_enable_gate});
    $display("test status done");
    // every documented source code, then a switch held by an unstable source
    @(posedge clock) hf_sel <= 1'b1;
    for (int i = 1; i < 5; i++) begin
      reg_wr(MCC_OFF_SEL, 8'(i % 4), 1, 0);
      wait_src(4'(i % 4));
      chk("hf input path", {7'h0, i == 3}, {7'h0, use_input});
    end
    @(posedge clock) osc[1] <= 1'b0;
    reg_wr(MCC_OFF_SEL, {4'h0, MCC_SRC_INT_32K}, 1, 0);
    rd_chk("switch pending", MCC_OFF_STATUS, exp_status(8'hFD, 1'b1));
    chk("source held", 8'h00, {4'h0, active_src});
    @(posedge clock) osc[1] <= 1'b1;
    wait_src(MCC_SRC_INT_32K);
    reg_wr(MCC_OFF_SEL, {4'h0, MCC_SRC_INT_HF}, 1, 0);
    wait_src(MCC_SRC_INT_HF);
    $display("test source select done");
    // every documented ratio code, then prescaler off
    foreach (codes[i]) begin
      reg_wr(MCC_OFF_PRESC, {3'b000, codes[i], 1'b1}, 1, 0);
      period(p);
      period(p);
      chk("divide ratio", 8'(ratio(codes[i])), 8'(p));
    end
    reg_wr(MCC_OFF_PRESC, 8'h00, 1, 0);
    period(p);
    period(p);
    chk("undivided", 8'h01, 8'(p));
    $display("test prescaler done");
    // real failure on the external hf source
    reg_wr(MCC_OFF_FDCTL, 8'h05, 1, 0);
    @(posedge clock) hf_fail <= 1'b1;
    look(4);
    rd_chk("failure flag", MCC_OFF_FLAGS, 8'h01);
    chk("masked request", 8'h00, {6'h0, irq, nmi});
    reg_wr(MCC_OFF_IRQCTL, 8'h01, 1, 0);
    look(1);
    chk("regular request", 8'h02, {6'h0, irq, nmi});
    reg_wr(MCC_OFF_FLAGS, 8'h00, 0, 0);
    rd_chk("flag after zero", MCC_OFF_FLAGS, 8'h01);
    reg_wr(MCC_OFF_FLAGS, 8'h01, 0, 0);
    rd_chk("flag cleared", MCC_OFF_FLAGS, 8'h00);
    slow_ticks(9);
    rd_chk("flag before repeat", MCC_OFF_FLAGS, 8'h00);
    slow_ticks(1);
    rd_chk("flag repeated", MCC_OFF_FLAGS, 8'h01);
    @(posedge clock) hf_fail <= 1'b0;
    reg_wr(MCC_OFF_FLAGS, 8'h01, 0, 0);
    $display("test detection done");
    // test bit with the detector off, then on
    reg_wr(MCC_OFF_FDCTL, 8'h06, 1, 0);
    rd_chk("detector off", MCC_OFF_FLAGS, 8'h00);
    rd_chk("test bit", MCC_OFF_FDCTL, 8'h06);
    reg_wr(MCC_OFF_FDCTL, 8'h07, 1, 0);
    rd_chk("forced failure", MCC_OFF_FLAGS, 8'h01);
    reg_wr(MCC_OFF_FDCTL, 8'h05, 1, 0);
    reg_wr(MCC_OFF_FLAGS, 8'h01, 0, 0);
    rd_chk("forced failure ended", MCC_OFF_FLAGS, 8'h00);
    // an unmonitored main stop is ignored, a stop of the watched 32k source is seen
    reg_wr(MCC_OFF_FDCTL, 8'h09, 1, 0);
    @(posedge clock) main_fail <= 1'b1;
    look(4);
    rd_chk("unmonitored failure", MCC_OFF_FLAGS, 8'h00);
    @(posedge clock) k32_fail <= 1'b1;
    look(4);
    rd_chk("32k failure", MCC_OFF_FLAGS, 8'h01);
    @(posedge clock) {main_fail, k32_fail} <= 2'b00;
    reg_wr(MCC_OFF_FLAGS, 8'h01, 0, 0);
    // forced failure of the monitored main clock falls back to the fused source
    reg_wr(MCC_OFF_SEL, 8'h80, 1, 0);
    reg_wr(MCC_OFF_FDCTL, 8'h03, 1, 0);
    wait_src(fuse_src);
    rd_chk("fallback select", MCC_OFF_SEL, {4'h0, fuse_src});
    chk("clock out dropped", 8'h00, {7'h0, main_clock_out_enable_gate});
    reg_wr(MCC_OFF_FDCTL, 8'h01, 1, 0);
    $display("test fallback done");
    // lock, then a reset in mid-run releases it
    reg_wr(MCC_OFF_IRQCTL, 8'h81, 1, 0);
    look(1);
    chk("nmi request", 8'h01, {6'h0, irq, nmi});
    reg_wr(MCC_OFF_FDCTL, 8'h08, 1, 0);
    rd_chk("locked detector", MCC_OFF_FDCTL, 8'h01);
    reg_wr(MCC_OFF_IRQCTL, 8'h00, 1, 0);
    rd_chk("locked irq ctrl", MCC_OFF_IRQCTL, 8'h81);
    reg_wr(MCC_OFF_FDCTL, 8'h03, 1, 0);
    rd_chk("test bit unlocked", MCC_OFF_FDCTL, 8'h03);
    @(posedge clock) rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    rd_chk("irq ctrl after reset", MCC_OFF_IRQCTL, 8'h00);
    reg_wr(MCC_OFF_IRQCTL, 8'h01, 1, 0);
    rd_chk("unlocked by reset", MCC_OFF_IRQCTL, 8'h01);
    $display("test lock done");
    summarize();
  end
endmodule : mcc_main_clock_ctrl_tb
